// ### rtl/lj_tx_consts.vh
`ifndef LJ_TX_CONSTS_VH
`define LJ_TX_CONSTS_VH
// Register byte offsets inside one device window
`define OFS_CTRL        8'h00
`define OFS_OFFSET      8'h04
`define OFS_SLOT_LO     8'h08
`define OFS_SLOT_HI     8'h0c
`define OFS_MASTER      8'h10
`define OFS_MANUAL      8'h14
`define OFS_STATUS      8'h18
`define OFS_SYNC        8'h1c
// Address windows: strap selects target, one bit marks broadcast
`define ADDR_WIN_LSB    10
`define ADDR_BCAST_BIT  12
// Control, status and slot register field positions
`define CTRL_TX_EN      0
`define CTRL_MASTER     1
`define CTRL_TRISTATE   2
`define CTRL_KEEPER     3
`define CTRL_LANE2      4
`define CTRL_DAISY      5
`define CTRL_LATCH      6
`define CTRL_BCLK_INV   7
`define CTRL_ERR_DIS    8
`define CTRL_AUTO_DIS   9
`define CTRL_WL_LSB     10
`define STS_ERR_BIT     8
`define SLOT_EN_BIT     6
// Reset values
`define CTRL_RST        12'h000
`define SLOT_RST        32'h03020100
`define SLOT_HI_RST     32'h07060504
`define OFFSET_RST      5'h00
`define MASTER_RST      28'h0400003
`define MANUAL_RST      8'h00
// Rate classification, frame periods in system clock cycles
`define CLK_HZ          40000000
`define PER_8K          (`CLK_HZ / 8000)
`define PER_16K         (`CLK_HZ / 16000)
`define PER_24K         (`CLK_HZ / 24000)
`define PER_32K         (`CLK_HZ / 32000)
`define PER_48K         (`CLK_HZ / 48000)
`define PER_96K         (`CLK_HZ / 96000)
`define PER_192K        (`CLK_HZ / 192000)
`define PER_384K        (`CLK_HZ / 384000)
`define PER_768K        (`CLK_HZ / 768000)
`define RATE_NONE       4'hf
`define RATIO_NONE      4'hf
`endif

// ### rtl/lj_audio_serial_tx_clock_detect.v
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "lj_tx_consts.vh"
// What this block does
// - Left slot 0 MSB with frame sync rise
// - Right slot 0 MSB with frame sync fall
// - Later bits launch on bit clock falls
// - Remaining slots follow slot 0, no gaps
// - Driven frame sync changes on clock fall
// - Strap pins choose one of four addresses
// - Broadcast write reaches every device
// - Any channel maps to 64 slots
// - Optional release of unowned slots
// - Optional keeper holds last data level
// - Second data lane on general pin
// - Daisy-chain data from general input
// - Latch option delays input one cycle
// - Clock master or clock slave
// - Devices resynchronise for common sampling
// - Measure frame and bit clock rates
// - Set dividers from detected rate, ratio
// - Accept only supported rate, ratio pairs
// - Bad combination flags error, mutes record
// - Codes 0-31 left, 32-63 right slots
// - Slot start delay 0 to 31 cycles
// - Separate disables for error, auto config
module lj_audio_serial_tx_clock_detect (
  input  wire         sys_clk_i,            // System clock, 40 MHz
  input  wire         rst_n_i,              // Synchronous reset, active low
  input  wire         ce_i,                 // Clock enable, freezes state when low
  input  wire         psel_i,
  input  wire         penable_i,
  input  wire         pwrite_i,
  input  wire [12:0]  paddr_i,
  input  wire [31:0]  pwdata_i,
  output reg  [31:0]  prdata_o,
  output wire         pready_o,
  output wire         pslverr_o,
  input  wire [1:0]   addr_strap_i,         // Address strap pins
  output wire [1:0]   target_addr_o,        // Captured control target address
  input  wire [255:0] chan_data_i,          // Eight channel words, left aligned
  output reg          sample_take_o,        // Channel words captured this cycle
  input  wire         bit_clock_i,
  output reg          bit_clock_o,
  output wire         bit_clock_oe_o,
  input  wire         frame_sync_pin_i,
  output reg          frame_sync_pin_o,
  output wire         frame_sync_pin_oe_o,
  output reg          serial_data_o,
  output reg          serial_data_oe_o,
  output reg          serial_keeper_o,      // Keeper holds the line
  output reg          general_io_pin_one_o, // Second data lane
  output reg          general_io_pin_one_oe_o,
  input  wire         general_input_pins_i, // Daisy-chain data in
  output wire [7:0]   clk_cfg_o,            // Divider setting {ratio, rate}
  output wire         clock_error_o,        // Clock error, sticky
  output wire         record_mute_o         // Mute for record channels
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Word length code to bit count minus one
  function [4:0] wl_last;
    input [1:0] code;
    begin
      case (code)
        2'd0:    wl_last = 5'd15;
        2'd1:    wl_last = 5'd19;
        2'd2:    wl_last = 5'd23;
        default: wl_last = 5'd31;
      endcase
    end
  endfunction

  // Bit clock count per frame to ratio index
  function [3:0] ratio_idx;
    input [11:0] n;
    begin
      case (n)
        12'd16:   ratio_idx = 4'h0;
        12'd24:   ratio_idx = 4'h1;
        12'd32:   ratio_idx = 4'h2;
        12'd48:   ratio_idx = 4'h3;
        12'd64:   ratio_idx = 4'h4;
        12'd96:   ratio_idx = 4'h5;
        12'd128:  ratio_idx = 4'h6;
        12'd192:  ratio_idx = 4'h7;
        12'd256:  ratio_idx = 4'h8;
        12'd384:  ratio_idx = 4'h9;
        12'd512:  ratio_idx = 4'ha;
        12'd1024: ratio_idx = 4'hb;
        12'd2048: ratio_idx = 4'hc;
        default:  ratio_idx = `RATIO_NONE;
      endcase
    end
  endfunction

  // Highest ratio index allowed at a rate index (8k .. 768k)
  function [3:0] ratio_max;
    input [3:0] r;
    begin
      case (r)
        4'd0:    ratio_max = 4'hc;
        4'd1:    ratio_max = 4'hb;
        4'd2:    ratio_max = 4'hb;
        4'd3:    ratio_max = 4'ha;
        4'd4:    ratio_max = 4'ha;
        4'd5:    ratio_max = 4'h8;
        4'd6:    ratio_max = 4'h6;
        4'd7:    ratio_max = 4'h4;
        default: ratio_max = 4'h2;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state

  reg  [11:0]  ctrl_reg;        // Control bits
  reg  [4:0]   offset_reg;      // Slot start delay
  reg  [31:0]  slot_lo_reg;     // Channels 0-3: enable + slot code
  reg  [31:0]  slot_hi_reg;     // Channels 4-7
  reg  [27:0]  master_reg;      // [7:0] half period minus one, [27:16] clocks per frame
  reg  [7:0]   manual_reg;      // Manual clock setting
  reg          err_reg;         // Sticky clock error
  reg  [3:0]   rate_reg;        // Detected rate index
  reg  [3:0]   ratio_reg;       // Detected ratio index
  reg          det_valid_reg;   // A frame sync rise was judged
  reg  [1:0]   strap_reg;       // Captured strap
  reg          strap_done_reg;  // Strap already captured
  reg          sync_reg;        // Resync pulse
  reg          bclk_prev_reg;   // Previous bit clock level
  reg          fs_prev_reg;     // Frame sync level at last fall
  reg          fs_rise_prev_reg;// Frame sync level at last rise
  reg  [4:0]   delay_cnt_reg;   // Offset countdown
  reg  [4:0]   bit_cnt_reg;     // Bit inside slot
  reg  [5:0]   slot_cnt_reg;    // {side, slot}
  reg          active_reg;      // Past the offset
  reg  [255:0] words_reg;       // Captured channel words
  reg  [1:0]   daisy_sh_reg;    // Daisy input history
  reg  [7:0]   div_cnt_reg;     // Master clock divider
  reg  [11:0]  mframe_cnt_reg;  // Master bit clock count
  reg  [15:0]  per_cnt_reg;     // System cycles per frame
  reg  [11:0]  bclk_cnt_reg;    // Bit clocks per frame

  wire         master  = ctrl_reg[`CTRL_MASTER];
  wire [4:0]   wl      = wl_last(ctrl_reg[`CTRL_WL_LSB+1:`CTRL_WL_LSB]);
  wire [63:0]  slots   = {slot_hi_reg, slot_lo_reg};

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states

  wire own_win   = (paddr_i[`ADDR_WIN_LSB+1:`ADDR_WIN_LSB] == strap_reg);
  wire bcast     = paddr_i[`ADDR_BCAST_BIT];
  wire [7:0] ofs = paddr_i[7:0];
  wire mapped    = (ofs[1:0] == 2'b00) && (ofs <= `OFS_SYNC) && paddr_i[9:8] == 2'b00;
  wire acc       = psel_i && penable_i && ce_i;
  wire wr_en     = acc && pwrite_i && mapped && (own_win || bcast);
  assign pready_o  = ce_i;
  assign pslverr_o = psel_i && penable_i && !mapped;
  assign target_addr_o = strap_reg;

  // Read mux; broadcast reads return zero since many slaves share them
  always @* begin
    prdata_o = 32'h0000_0000;
    if (psel_i && !pwrite_i && own_win && !bcast) begin
      case (ofs)
        `OFS_CTRL:    prdata_o = {20'h00000, ctrl_reg};
        `OFS_OFFSET:  prdata_o = {27'h0000000, offset_reg};
        `OFS_SLOT_LO: prdata_o = slot_lo_reg;
        `OFS_SLOT_HI: prdata_o = slot_hi_reg;
        `OFS_MASTER:  prdata_o = {4'h0, master_reg};
        `OFS_MANUAL:  prdata_o = {24'h000000, manual_reg};
        `OFS_STATUS:  prdata_o = {22'h000000, det_valid_reg, err_reg, ratio_reg, rate_reg};
        default:      prdata_o = 32'h0000_0000;
      endcase
    end
  end

  // Register writes, strap capture and resync pulse
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ctrl_reg       <= `CTRL_RST;
      offset_reg     <= `OFFSET_RST;
      slot_lo_reg    <= `SLOT_RST;
      slot_hi_reg    <= `SLOT_HI_RST;
      master_reg     <= `MASTER_RST;
      manual_reg     <= `MANUAL_RST;
      strap_reg      <= 2'b00;
      strap_done_reg <= 1'b0;
      sync_reg       <= 1'b0;
    end else if (ce_i) begin
      // Strap is read once after release, never under reset
      if (!strap_done_reg) begin
        strap_reg      <= addr_strap_i;
        strap_done_reg <= 1'b1;
      end
      sync_reg <= wr_en && (ofs == `OFS_SYNC);
      if (wr_en) begin
        case (ofs)
          `OFS_CTRL:    ctrl_reg    <= pwdata_i[11:0];
          `OFS_OFFSET:  offset_reg  <= pwdata_i[4:0];
          `OFS_SLOT_LO: slot_lo_reg <= pwdata_i;
          `OFS_SLOT_HI: slot_hi_reg <= pwdata_i;
          `OFS_MASTER:  master_reg  <= pwdata_i[27:0];
          `OFS_MANUAL:  manual_reg  <= pwdata_i[7:0];
          default: ;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Master clock generation: bit clock from a divider, frame sync from count

  assign bit_clock_oe_o      = master;
  assign frame_sync_pin_oe_o = master;

  // Divider toggles the bit clock; frame sync only moves on the falling half
  always @(posedge sys_clk_i) begin
    if (!rst_n_i || sync_reg) begin
      div_cnt_reg      <= 8'h00;
      mframe_cnt_reg   <= 12'h000;
      bit_clock_o      <= 1'b0;
      frame_sync_pin_o <= 1'b0;
    end else if (ce_i && master) begin
      if (div_cnt_reg >= master_reg[7:0]) begin
        div_cnt_reg <= 8'h00;
        bit_clock_o <= !bit_clock_o;
        if (bit_clock_o) begin
          // High half of frame carries left slots, low half right slots
          if (mframe_cnt_reg >= master_reg[27:16] - 12'd1)
            mframe_cnt_reg <= 12'h000;
          else
            mframe_cnt_reg <= mframe_cnt_reg + 12'd1;
          frame_sync_pin_o <= (mframe_cnt_reg >= master_reg[27:16] - 12'd1) ||
                              (mframe_cnt_reg < {1'b0, master_reg[27:17]} - 12'd1);
        end
      end else begin
        div_cnt_reg <= div_cnt_reg + 8'h01;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bit clock edge detection on the shared timing source

  // Inputs are synchronous; in master mode the own clock is used directly
  wire bclk_lvl = (master ? bit_clock_o : bit_clock_i) ^ ctrl_reg[`CTRL_BCLK_INV];
  wire fs_lvl   = master ? frame_sync_pin_o : frame_sync_pin_i;
  wire bclk_fall = bclk_prev_reg && !bclk_lvl;
  wire bclk_rise = !bclk_prev_reg && bclk_lvl;

  ////////////////////////////////////////////////////////////////////////////
  // Slot sequencing

  // Owner lookup for the current slot on each lane
  reg        own_hit;    // Primary lane owns slot
  reg  [2:0] own_ch;
  reg        own2_hit;   // Second lane owns slot
  reg  [2:0] own2_ch;
  integer    k;
  always @* begin
    own_hit  = 1'b0;
    own_ch   = 3'd0;
    own2_hit = 1'b0;
    own2_ch  = 3'd0;
    for (k = 7; k >= 0; k = k - 1) begin
      // Code 0-31 left group, 32-63 right group, as slot counter holds
      if (slots[k*8+`SLOT_EN_BIT] && slots[k*8 +: 6] == slot_cnt_reg) begin
        if (ctrl_reg[`CTRL_LANE2] && k >= 4) begin
          own2_hit = 1'b1;
          own2_ch  = k[2:0];
        end else begin
          own_hit = 1'b1;
          own_ch  = k[2:0];
        end
      end
    end
  end

  // Data bit of a channel, MSB first from the left-aligned word
  wire [7:0] bit_sel  = {own_ch, 5'd31 - bit_cnt_reg};
  wire [7:0] bit2_sel = {own2_ch, 5'd31 - bit_cnt_reg};
  wire       lane1_bit = words_reg[bit_sel];
  wire       lane2_bit = words_reg[bit2_sel];
  wire       daisy_bit = ctrl_reg[`CTRL_LATCH] ? daisy_sh_reg[1] : daisy_sh_reg[0];

  // Counters advance only on bit clock falls; a frame sync change restarts
  always @(posedge sys_clk_i) begin
    if (!rst_n_i || sync_reg) begin
      bclk_prev_reg <= bclk_lvl; // Idle level, so no false edge follows reset
      fs_prev_reg   <= 1'b0;
      delay_cnt_reg <= 5'h00;
      bit_cnt_reg   <= 5'h00;
      slot_cnt_reg  <= 6'h00;
      active_reg    <= 1'b0;
      words_reg     <= 256'h0;
      sample_take_o <= 1'b0;
      daisy_sh_reg  <= 2'b00;
    end else if (ce_i) begin
      bclk_prev_reg <= bclk_lvl;
      sample_take_o <= 1'b0;
      if (bclk_fall) begin
        fs_prev_reg  <= fs_lvl;
        daisy_sh_reg <= {daisy_sh_reg[0], general_input_pins_i};
        if (fs_lvl != fs_prev_reg) begin
          // Group start: rise starts left slots, fall starts right slots
          slot_cnt_reg  <= {!fs_lvl, 5'h00};
          bit_cnt_reg   <= 5'h00;
          delay_cnt_reg <= offset_reg;
          active_reg    <= (offset_reg == 5'h00);
          if (fs_lvl) begin
            words_reg     <= chan_data_i;
            sample_take_o <= 1'b1;
          end
        end else if (!active_reg) begin
          if (delay_cnt_reg <= 5'h01)
            active_reg <= 1'b1;
          delay_cnt_reg <= delay_cnt_reg - 5'h01;
        end else if (bit_cnt_reg >= wl) begin
          // Next slot follows at once; stays inside its group
          bit_cnt_reg  <= 5'h00;
          slot_cnt_reg <= {slot_cnt_reg[5], slot_cnt_reg[4:0] + 5'h01};
        end else begin
          bit_cnt_reg <= bit_cnt_reg + 5'h01;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output lanes, registered so they move with the falling bit clock

  // The output lags the fall detect by one system cycle; a slot that nobody
  // owns is released, forwarded from the chain or driven low
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      serial_data_o           <= 1'b0;
      serial_data_oe_o        <= 1'b0;
      serial_keeper_o         <= 1'b0;
      general_io_pin_one_o    <= 1'b0;
      general_io_pin_one_oe_o <= 1'b0;
    end else if (ce_i) begin
      if (!ctrl_reg[`CTRL_TX_EN]) begin
        serial_data_oe_o        <= 1'b0;
        general_io_pin_one_oe_o <= 1'b0;
        serial_keeper_o         <= ctrl_reg[`CTRL_KEEPER];
      end else begin
        if (active_reg && own_hit) begin
          serial_data_o    <= lane1_bit;
          serial_data_oe_o <= 1'b1;
          serial_keeper_o  <= 1'b0;
        end else if (active_reg && ctrl_reg[`CTRL_DAISY]) begin
          serial_data_o    <= daisy_bit;
          serial_data_oe_o <= 1'b1;
          serial_keeper_o  <= 1'b0;
        end else if (ctrl_reg[`CTRL_TRISTATE]) begin
          // Released line keeps last level only through the keeper
          serial_data_oe_o <= 1'b0;
          serial_keeper_o  <= ctrl_reg[`CTRL_KEEPER];
        end else begin
          serial_data_o    <= 1'b0;
          serial_data_oe_o <= 1'b1;
          serial_keeper_o  <= 1'b0;
        end
        // Second lane only exists while enabled
        general_io_pin_one_oe_o <= ctrl_reg[`CTRL_LANE2] &&
                                   ((active_reg && own2_hit) || !ctrl_reg[`CTRL_TRISTATE]);
        general_io_pin_one_o    <= active_reg && own2_hit && lane2_bit;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock configuration detector

  // Period classification uses midpoints between neighbouring rates
  reg [3:0] rate_now;
  always @* begin
    if (per_cnt_reg > (`PER_8K + `PER_8K / 4))               rate_now = `RATE_NONE;
    else if (per_cnt_reg > (`PER_8K + `PER_16K) / 2)         rate_now = 4'd0;
    else if (per_cnt_reg > (`PER_16K + `PER_24K) / 2)        rate_now = 4'd1;
    else if (per_cnt_reg > (`PER_24K + `PER_32K) / 2)        rate_now = 4'd2;
    else if (per_cnt_reg > (`PER_32K + `PER_48K) / 2)        rate_now = 4'd3;
    else if (per_cnt_reg > (`PER_48K + `PER_96K) / 2)        rate_now = 4'd4;
    else if (per_cnt_reg > (`PER_96K + `PER_192K) / 2)       rate_now = 4'd5;
    else if (per_cnt_reg > (`PER_192K + `PER_384K) / 2)      rate_now = 4'd6;
    else if (per_cnt_reg > (`PER_384K + `PER_768K) / 2)      rate_now = 4'd7;
    else if (per_cnt_reg > (`PER_768K - `PER_768K / 4))      rate_now = 4'd8;
    else                                                     rate_now = `RATE_NONE;
  end

  wire [3:0] ratio_now = ratio_idx(bclk_cnt_reg);
  // Ratios 16 and 24 are reserved at 8 kHz; above that the table caps the ratio
  wire pair_ok = (rate_now != `RATE_NONE) && (ratio_now != `RATIO_NONE) &&
                 (ratio_now <= ratio_max(rate_now)) &&
                 !(rate_now == 4'd0 && ratio_now < 4'd2);
  wire frame_edge = bclk_rise && fs_lvl && !fs_rise_prev_reg;
  wire err_clr    = wr_en && (ofs == `OFS_STATUS) && pwdata_i[`STS_ERR_BIT];
  wire err_set    = frame_edge && !pair_ok && !ctrl_reg[`CTRL_ERR_DIS];

  // Count across one frame, judged at each frame sync rise
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fs_rise_prev_reg <= 1'b0;
      per_cnt_reg      <= 16'h0000;
      bclk_cnt_reg     <= 12'h000;
      rate_reg         <= `RATE_NONE;
      ratio_reg        <= `RATIO_NONE;
      det_valid_reg    <= 1'b0;
      err_reg          <= 1'b0;
    end else if (ce_i) begin
      // Saturating counters keep a stopped clock reading as out of range
      if (per_cnt_reg != 16'hffff)
        per_cnt_reg <= per_cnt_reg + 16'h0001;
      if (bclk_rise) begin
        fs_rise_prev_reg <= fs_lvl;
        if (bclk_cnt_reg != 12'hfff)
          bclk_cnt_reg <= bclk_cnt_reg + 12'h001;
      end
      if (frame_edge) begin
        per_cnt_reg   <= 16'h0001;
        bclk_cnt_reg  <= 12'h001;
        rate_reg      <= rate_now;
        ratio_reg     <= ratio_now;
        det_valid_reg <= 1'b1;
      end
      // A new error in the clearing cycle is kept
      if (err_set)
        err_reg <= 1'b1;
      else if (err_clr)
        err_reg <= 1'b0;
    end
  end

  // Auto setting unless disabled, then the manual setting applies
  assign clk_cfg_o     = ctrl_reg[`CTRL_AUTO_DIS] ? manual_reg : {ratio_reg, rate_reg};
  assign clock_error_o = err_reg;
  assign record_mute_o = err_reg;

endmodule // lj_audio_serial_tx_clock_detect

// ### testbench/lj_host_model.sv
`timescale 1ns/1ps
// Host receiver: makes bit clock and frame sync, samples data on bit clock rises
module lj_host_model (
  input  wire        clk_i,  // System clock
  input  wire        sd_i,   // Data line level
  input  wire        oe_i,   // Data line driven
  output reg         bclk_o, // Bit clock, stands high between frames
  output reg         fs_o,   // Frame sync, high for the left half
  output reg  [63:0] rx_o,   // Last bits received, oldest first
  output reg  [63:0] ox_o    // Drive flags seen with those bits
);
  initial {bclk_o, fs_o} = 2'b10;
  ////////////////////////////////////////////////////////////
  // n frames of bits clocks, half period h system cycles
  task automatic run(input int bits, input int h, input int n);
    int f;
    int b;
    for (f = 0; f < n; f++) begin
      for (b = 0; b < bits; b++) begin
        @(posedge clk_i);
        bclk_o <= 1'b0;
        fs_o   <= (b < bits / 2);
        repeat (h) @(posedge clk_i);
        bclk_o <= 1'b1;
        rx_o   <= {rx_o[62:0], sd_i};
        ox_o   <= {ox_o[62:0], oe_i};
        repeat (h - 1) @(posedge clk_i);
      end
    end
  endtask
endmodule // lj_host_model

// ### testbench/lj_audio_serial_tx_clock_detect_props.sv
`timescale 1ns/1ps
// Port checks for the serial transmitter
module lj_props (
  input wire        sys_clk_i,
  input wire        rst_n_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [12:0] paddr_i,
  input wire [31:0] prdata_o,
  input wire [1:0]  addr_strap_i,
  input wire [1:0]  target_addr_o,
  input wire        bit_clock_i,
  input wire        bit_clock_o,
  input wire        bit_clock_oe_o,
  input wire        frame_sync_pin_o,
  input wire        frame_sync_pin_oe_o,
  input wire        serial_data_o,
  input wire        serial_data_oe_o,
  input wire        serial_keeper_o,
  input wire        clock_error_o,
  input wire        record_mute_o
);
  reg [3:0] bh_reg; // Recent bit clock samples, wide enough to span the launch delay
  always @(posedge sys_clk_i) bh_reg <= {bh_reg[2:0], bit_clock_i};
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  data_on_fall_a: assert property ($changed(serial_data_o) && serial_data_oe_o |-> |(bh_reg[3:1] & ~bh_reg[2:0]))
    else $error("data moved off a fall");
  frame_sync_pin_on_fall_a: assert property ($changed(frame_sync_pin_o) && frame_sync_pin_oe_o |-> !bit_clock_o)
    else $error("frame sync moved off a fall");
  master_oe_a: assert property (bit_clock_oe_o == frame_sync_pin_oe_o)
    else $error("clock drives disagree");
  err_mutes_a: assert property (clock_error_o |-> record_mute_o)
    else $error("error without mute");
  err_sticky_a: assert property (clock_error_o && !(psel_i && penable_i && pwrite_i) |=> clock_error_o)
    else $error("error dropped alone");
  keeper_off_a: assert property (serial_keeper_o |-> !serial_data_oe_o)
    else $error("keeper while driving");
  strap_target_a: assert property (rst_n_i && $past(rst_n_i) |=> target_addr_o == addr_strap_i)
    else $error("target differs from strap");
  bcast_read_a: assert property (psel_i && penable_i && !pwrite_i && paddr_i[12] |-> prdata_o == 32'h0)
    else $error("broadcast read not zero");
  cover property ($rose(serial_data_oe_o));
  cover property ($rose(clock_error_o));
  cover property ($rose(bit_clock_oe_o));
endmodule // lj_props
bind lj_audio_serial_tx_clock_detect lj_props u_props (.sys_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .prdata_o, .addr_strap_i, .target_addr_o, .bit_clock_i, .bit_clock_o, .bit_clock_oe_o, .frame_sync_pin_o,
  .frame_sync_pin_oe_o, .serial_data_o, .serial_data_oe_o, .serial_keeper_o, .clock_error_o, .record_mute_o);

// ### testbench/lj_audio_serial_tx_clock_detect_tb.sv
`timescale 1ns/1ps
`include "lj_tx_consts.vh"
module lj_audio_serial_tx_clock_detect_tb;
  reg          sys_clk_i = 1'b0;
  reg          rst_n_i = 1'b0;
  reg          ce_i = 1'b1;
  reg          psel_i = 1'b0;
  reg          penable_i = 1'b0;
  reg          pwrite_i = 1'b0;
  reg  [12:0]  paddr_i = 13'h0;
  reg  [31:0]  pwdata_i = 32'h0;
  reg  [255:0] chan = {192'h0, 32'h3c5a1111, 32'ha5c32222}; // Low bits must never be sent
  wire [31:0]  prdata_o;
  wire         pready_o, pslverr_o, sd_o, sd_oe, keep, fs_o, fs_oe, bc_o, bc_oe, hb, hfs, err, mute, g, goe;
  wire [1:0]   tgt;
  wire [7:0]   cfg;
  wire [63:0]  rx, ox;
  wire         bclk_w = bc_oe ? bc_o : hb;    // Shared bit clock wire
  wire         fs_w = fs_oe ? fs_o : hfs;     // Shared frame sync wire
  wire         sd_w = sd_o ^ (~sd_oe & ~keep); // Released line shows the inverse unless held
  localparam   [12:0] own = 13'h0800;         // Window chosen by strap 2
  int          miscompares = 0;
  int          total_checks = 0;
  int          cyc = 0;
  reg  [31:0]  q;
  reg          e;
  always #12.5 sys_clk_i = ~sys_clk_i;
  lj_audio_serial_tx_clock_detect dut (.sys_clk_i, .rst_n_i, .ce_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .addr_strap_i(2'b10), .target_addr_o(tgt), .chan_data_i(chan),
    .sample_take_o(), .bit_clock_i(bclk_w), .bit_clock_o(bc_o), .bit_clock_oe_o(bc_oe), .frame_sync_pin_i(fs_w),
    .frame_sync_pin_o(fs_o), .frame_sync_pin_oe_o(fs_oe), .serial_data_o(sd_o), .serial_data_oe_o(sd_oe),
    .serial_keeper_o(keep), .general_io_pin_one_o(g), .general_io_pin_one_oe_o(goe), .general_input_pins_i(1'b0),
    .clk_cfg_o(cfg), .clock_error_o(err), .record_mute_o(mute));
  lj_host_model host (.clk_i(sys_clk_i), .sd_i(sd_w), .oe_i(sd_oe), .bclk_o(hb), .fs_o(hfs), .rx_o(rx), .ox_o(ox));
  ////////////////////////////////////////////////////////////
  task check(input [63:0] got, input [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; read data and error taken at the ready edge
  task bus(input w, input [12:0] a, input [31:0] d);
    @(posedge sys_clk_i);
    {psel_i, pwrite_i, paddr_i, pwdata_i} <= {1'b1, w, a, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do @(posedge sys_clk_i); while (pready_o !== 1'b1);
    q = prdata_o;
    e = pslverr_o;
    {psel_i, penable_i} <= 2'b00;
  endtask
  // Configure, send one 64 clock frame, compare what the host saw
  task frame(input [31:0] ctl, input [31:0] slot, input [63:0] ed, input [63:0] eo);
    bus(1, own | `OFS_CTRL, ctl);
    bus(1, own | `OFS_SLOT_LO, slot);
    host.run(64, 4, 1);
    check(rx & ox, ed);
    check(ox, eo);
  endtask
  task wrap_up;
    $display("Checks made: %0d, mismatches: %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Hang guard, well above the roughly 34000 cycles the sequence needs
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      miscompares++;
      wrap_up;
    end
  end
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    check(cfg, 8'hff);
    check(tgt, 2'b10);
    bus(0, own | `OFS_SLOT_LO, 0);
    check(q, `SLOT_RST);
    frame(32'h101, 32'h6041, {16'h0, 16'ha5c3, 16'h3c5a, 16'h0}, {64{1'b1}});
    bus(1, 13'h0400 | `OFS_OFFSET, 32'h1f);
    bus(0, own | `OFS_OFFSET, 0);
    check(q, 32'h0);
    bus(1, 13'h1000 | `OFS_OFFSET, 32'h5);
    bus(0, own | `OFS_OFFSET, 0);
    check(q, 32'h5);
    bus(0, 13'h1000 | `OFS_OFFSET, 0);
    check(q, 32'h0);
    bus(0, own | 13'h20, 0);
    check(e, 1'b1);
    frame(32'h10d, 32'h6040, {5'h0, 16'ha5c3, 11'h0, 5'h0, 16'h3c5a, 11'h0},
      {5'h0, 16'hffff, 11'h0, 5'h0, 16'hffff, 11'h0});
    check({keep, goe, g}, 3'b100);
    bus(1, own | `OFS_CTRL, 32'h100);
    host.run(32, 13, 3);
    check(cfg, 8'h24);
    host.run(16, 156, 3);
    check({err, mute}, 2'b00);
    bus(1, own | `OFS_CTRL, 32'h0);
    host.run(16, 156, 3);
    check({err, mute}, 2'b11);
    bus(1, own | `OFS_STATUS, 32'h100);
    bus(0, own | `OFS_STATUS, 0);
    check(q[8], 1'b0);
    bus(1, own | `OFS_CTRL, 32'h103);
    repeat (200) @(posedge sys_clk_i);
    check({bc_oe, fs_oe}, 2'b11);
    bus(1, own | `OFS_CTRL, 32'h2);
    bus(1, own | `OFS_SYNC, 32'h0);
    repeat (2) @(posedge sys_clk_i);
    check({bc_o, fs_o}, 2'b00);
    wrap_up;
  end
endmodule // lj_audio_serial_tx_clock_detect_tb
